// file: hdl/rsc_regs.sv
// Regulator power-down and output slew control registers on AHB-Lite.
// Assumes a single-master AHB-Lite bus on hclk; wake pin and alarm are asynchronous.
// What this block does
// - Bandgap shutdown bit set turns off regulators, reset circuit and bandgap.
// - Wake pin high or clock alarm restores whatever the shutdown bits turned off.
// - Regulator shutdown bit set turns off regulators and reset circuit, bandgap stays.
// - Slew register bit 2 picks clock pin edge rate, 1 fast, 0 slow.
// - Slew register bit 0 picks memory port edge rate, 1 fast, 0 slow.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module rsc_regs
(
  // Clock and reset
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  // AHB-Lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  // Wake sources
  input  wire logic                          wake_pin,
  input  wire logic                          rtc_alarm,
  // Analog and pad controls
  output rsc_pkg::rsc_power_t                power_ctl,
  output rsc_pkg::rsc_slew_t                 slew_ctl,
  output logic                               rtc_clock_output_gate
);
  import rsc_pkg::*;

  // ----------------------------------------------------------------
  // Wake synchronisers
  // ----------------------------------------------------------------
  logic wake_s;
  logic alarm_s;

  rsc_sync u_wake
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d_in    (wake_pin),
    .q_out   (wake_s)
  );

  rsc_sync u_alarm
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d_in    (rtc_alarm),
    .q_out   (alarm_s)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Full compare of the decoded byte address against one register
  function automatic logic rsc_addr_hit
  (
    input logic [RSC_ADDR_W-1:0] addr,
    input logic [RSC_ADDR_W-1:0] reg_addr
  );
    return addr == reg_addr;
  endfunction

  // Write data limited to the implemented bits
  function automatic logic [2:0] rsc_wr_bits
  (
    input logic [31:0] data,
    input logic [2:0]  mask
  );
    return data[2:0] & mask;
  endfunction

  // ----------------------------------------------------------------
  // Address phase capture
  // ----------------------------------------------------------------
  logic                  wr_pend_reg;
  logic [RSC_ADDR_W-1:0] wr_addr_reg;
  logic [2:0]            pmgt_reg;
  logic [2:0]            pmgt_next;
  logic [2:0]            slew_reg;
  logic [2:0]            slew_next;

  wire                   addr_valid = hsel && hready && htrans[1];
  wire                   wr_start   = addr_valid && hwrite && (hsize == RSC_HSIZE_WORD);
  wire                   rd_start   = addr_valid && !hwrite;
  wire [RSC_ADDR_W-1:0]  a_now      = haddr[RSC_ADDR_W-1:0];
  wire                   wr_pmgt    = wr_pend_reg && rsc_addr_hit(wr_addr_reg, RSC_ADDR_PMGT);
  wire                   wr_slew    = wr_pend_reg && rsc_addr_hit(wr_addr_reg, RSC_ADDR_SLEW);
  wire                   rd_pmgt    = rsc_addr_hit(a_now, RSC_ADDR_PMGT);
  wire                   rd_slew    = rsc_addr_hit(a_now, RSC_ADDR_SLEW);
  wire                   wake_evt   = wake_s || alarm_s;

  // Read mux; unmapped addresses and reserved bits read zero
  wire [31:0]            rd_value   = rd_pmgt ? {29'h0, pmgt_reg} :
                                      rd_slew ? {29'h0, slew_reg} : 32'h0;

  // Wake clears both shutdown bits and wins over a write in the same cycle
  wire [2:0]             pm_written = wr_pmgt ? rsc_wr_bits(hwdata, RSC_PM_MASK) : pmgt_reg;
  wire [2:0]             wake_clr   = {wake_evt, wake_evt, 1'b0};

  always_comb
  begin
    pmgt_next = pm_written & ~wake_clr;
    slew_next = wr_slew ? rsc_wr_bits(hwdata, RSC_SL_MASK) : slew_reg;
  end

  // Bus capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hrdata      <= 32'h0;
    end
    else
    begin
      wr_pend_reg <= wr_start;
      wr_addr_reg <= wr_start ? a_now : wr_addr_reg;
      hrdata      <= rd_start ? rd_value : 32'h0;
    end
  end

  // Register storage
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pmgt_reg <= RSC_PM_RESET;
      slew_reg <= RSC_SL_RESET;
    end
    else
    begin
      pmgt_reg <= pmgt_next;
      slew_reg <= slew_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs from flops
  // ----------------------------------------------------------------
  // Bandgap stays up unless its own bit is set
  wire bg_off  = pmgt_next[RSC_PM_BANDGAP_SHUTDOWN_BIT];
  wire reg_off = pmgt_next[RSC_PM_BANDGAP_SHUTDOWN_BIT] || pmgt_next[RSC_PM_REG_PD];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      power_ctl <= '1;
    end
    else
    begin
      power_ctl.bandgap_on           <= !bg_off;
      power_ctl.por_on               <= !reg_off;
      power_ctl.analog_regulator_on  <= !reg_off;
      power_ctl.core_regulator_on    <= !reg_off;
      power_ctl.phy_regulator_on     <= !reg_off;
    end
  end

  // Pad controls
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      slew_ctl.clock_pin_slew_select   <= RSC_SL_RESET[RSC_SL_CLK];
      slew_ctl.memory_port_slew_select <= RSC_SL_RESET[RSC_SL_MEM];
      rtc_clock_output_gate            <= RSC_PM_RESET[RSC_PM_CLKOUT];
    end
    else
    begin
      slew_ctl.clock_pin_slew_select   <= slew_next[RSC_SL_CLK];
      slew_ctl.memory_port_slew_select <= slew_next[RSC_SL_MEM];
      rtc_clock_output_gate            <= pmgt_next[RSC_PM_CLKOUT];
    end
  end

  // Bus response, zero wait states
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_BG_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    pmgt_reg[RSC_PM_BANDGAP_SHUTDOWN_BIT] |-> !power_ctl.bandgap_on && !power_ctl.por_on && !power_ctl.core_regulator_on)
    else $error("bandgap shutdown not reflected");

  AST_BG_ON: assert property (@(posedge hclk) disable iff (!hresetn)
    (pmgt_reg[2:1] == 2'b00) |-> power_ctl.bandgap_on && power_ctl.analog_regulator_on && power_ctl.phy_regulator_on)
    else $error("supplies off with both shutdown bits clear");

  AST_REG_ONLY: assert property (@(posedge hclk) disable iff (!hresetn)
    (pmgt_reg[2:1] == 2'b01) |-> power_ctl.bandgap_on && !power_ctl.analog_regulator_on && !power_ctl.por_on)
    else $error("regulator shutdown wrong");

  AST_WAKE: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_evt |=> (pmgt_reg[2:1] == 2'b00) && power_ctl.bandgap_on && power_ctl.por_on)
    else $error("wake did not restore supplies");

  AST_WAKE_PIN: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(wake_pin) ##0 wake_pin [*3] |=> ##[0:1] !pmgt_reg[RSC_PM_REG_PD])
    else $error("wake pin ignored");

  AST_CLK_SLEW: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_slew |=> slew_ctl.clock_pin_slew_select == $past(hwdata[2]))
    else $error("clock pin slew not written");

  AST_MEM_SLEW: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_slew |=> slew_ctl.memory_port_slew_select == $past(hwdata[0]) && !slew_reg[1])
    else $error("memory port slew mismatch");

  AST_CLKOUT: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pmgt && !wake_evt |=> rtc_clock_output_gate == $past(hwdata[0]))
    else $error("clock output gate not written");

  AST_RSVD: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_start |=> hrdata[31:3] == 29'h0)
    else $error("reserved bits read nonzero");

  // ----------------------------------------------------------------
  // Power register checks
  // ----------------------------------------------------------------
  AST_PM_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pmgt && !wake_evt |=> pmgt_reg == ($past(hwdata[2:0]) & RSC_PM_MASK))
    else $error("power register write lost");

  AST_WAKE_WINS: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pmgt && wake_evt |=> pmgt_reg[2:1] == 2'b00)
    else $error("write overrode wake");

  AST_WAKE_ALL: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_evt |=> power_ctl == 5'h1F)
    else $error("wake left a supply off");

  AST_ALARM: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(rtc_alarm) ##0 rtc_alarm [*3] |=> ##[0:1] !pmgt_reg[RSC_PM_BANDGAP_SHUTDOWN_BIT])
    else $error("alarm ignored");

  AST_SUPPLY_GROUP: assert property (@(posedge hclk) disable iff (!hresetn)
    (power_ctl.por_on == power_ctl.analog_regulator_on) && (power_ctl.core_regulator_on == power_ctl.phy_regulator_on)
    && (power_ctl.por_on == power_ctl.core_regulator_on))
    else $error("regulators and reset circuit split");

  AST_BG_IMPLIES: assert property (@(posedge hclk) disable iff (!hresetn)
    !power_ctl.bandgap_on |-> !power_ctl.por_on && !power_ctl.phy_regulator_on && !power_ctl.analog_regulator_on)
    else $error("regulator on without bandgap");

  AST_GATE_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_pmgt |=> rtc_clock_output_gate == $past(rtc_clock_output_gate))
    else $error("clock output gate changed without write");

  // ----------------------------------------------------------------
  // Slew register checks
  // ----------------------------------------------------------------
  AST_SLEW_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_slew |=> slew_ctl == $past(slew_ctl))
    else $error("slew changed without write");

  AST_SLEW_RSVD: assert property (@(posedge hclk) disable iff (!hresetn)
    slew_reg[1] == 1'b0)
    else $error("reserved slew bit set");

  AST_NARROW_WR: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_valid && hwrite && (hsize != RSC_HSIZE_WORD) |=> ##1 slew_reg == $past(slew_reg))
    else $error("narrow write took effect");

  AST_UNMAPPED_WR: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_reg && !wr_pmgt && !wr_slew |=> slew_reg == $past(slew_reg)
    && pmgt_reg[RSC_PM_CLKOUT] == $past(pmgt_reg[RSC_PM_CLKOUT]))
    else $error("unmapped write took effect");

  // ----------------------------------------------------------------
  // Read data checks
  // ----------------------------------------------------------------
  AST_RD_PMGT: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_start && rd_pmgt |=> hrdata == {29'h0, $past(pmgt_reg)})
    else $error("power register read wrong");

  AST_RD_SLEW: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_start && rd_slew |=> hrdata == {29'h0, $past(slew_reg)})
    else $error("slew register read wrong");

  AST_RD_MISS: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_start && !rd_pmgt && !rd_slew |=> hrdata == 32'h0)
    else $error("unmapped read nonzero");

  AST_RD_IDLE: assert property (@(posedge hclk) disable iff (!hresetn)
    !rd_start |=> hrdata == 32'h0)
    else $error("read data outside read");

endmodule

// file: hdl/rsc_pkg.sv
// Package for the regulator and slew control register bank.
// Assumes a 32-bit AHB-Lite bus; registers at word-aligned byte addresses.
package rsc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Printed offsets are word indexes; byte address is four times the index
  localparam logic [15:0] RSC_IDX_PMGT    = 16'h1930;
  localparam logic [15:0] RSC_IDX_SLEW    = 16'h1C16;
  localparam logic [17:0] RSC_ADDR_PMGT   = {RSC_IDX_PMGT, 2'b00};
  localparam logic [17:0] RSC_ADDR_SLEW   = {RSC_IDX_SLEW, 2'b00};
  localparam int          RSC_ADDR_W      = 18;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          RSC_PM_CLKOUT   = 0;
  localparam int          RSC_PM_REG_PD   = 1;
  localparam int          RSC_PM_BANDGAP_SHUTDOWN_BIT    = 2;
  localparam int          RSC_SL_MEM      = 0;
  localparam int          RSC_SL_CLK      = 2;
  localparam logic [2:0]  RSC_PM_RESET    = 3'h0;
  localparam logic [2:0]  RSC_PM_MASK     = 3'h7;
  localparam logic [2:0]  RSC_SL_RESET    = 3'h5;
  localparam logic [2:0]  RSC_SL_MASK     = 3'h5;

  // ----------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0]  RSC_HTRANS_NSEQ = 2'h2;
  localparam logic [1:0]  RSC_HTRANS_SEQ  = 2'h3;
  localparam logic [2:0]  RSC_HSIZE_WORD  = 3'h2;

  // Analog enables driven to the power block
  typedef struct packed {
    logic bandgap_on;
    logic por_on;
    logic analog_regulator_on;
    logic core_regulator_on;
    logic phy_regulator_on;
  } rsc_power_t;

  // Slew selects, 1 is fast
  typedef struct packed {
    logic clock_pin_slew_select;
    logic memory_port_slew_select;
  } rsc_slew_t;

endpackage

// file: hdl/rsc_sync.sv
// Two-flop synchroniser for one level.
// Assumes the input is asynchronous to hclk.
`timescale 1ns/1ps
module rsc_sync
(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Data
  input  wire logic d_in,
  output logic      q_out
);
  logic stage1_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stage1_reg <= 1'b0;
      q_out      <= 1'b0;
    end
    else
    begin
      stage1_reg <= d_in;
      q_out      <= stage1_reg;
    end
  end
endmodule

// file: bench/rsc_regs_tb.sv
// Self-checking bench for the regulator and slew control register bank.
// Assumes rsc_pkg compiled first; the bench is the only AHB-Lite master.
`timescale 1ns/1ps
module rsc_regs_tb;
  import rsc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = RSC_HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  logic        wake_pin = 1'b0;
  logic        rtc_alarm = 1'b0;
  rsc_power_t  power_ctl;
  rsc_slew_t   slew_ctl;
  wire         gate;
  int          num_errors = 0;
  int          check_count = 0;
  localparam logic [31:0] PM = {14'h0, RSC_ADDR_PMGT};
  localparam logic [31:0] SL = {14'h0, RSC_ADDR_SLEW};
  always #5 hclk = ~hclk;
  rsc_regs u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wake_pin(wake_pin), .rtc_alarm(rtc_alarm),
    .power_ctl(power_ctl), .slew_ctl(slew_ctl), .rtc_clock_output_gate(gate));
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic [31:0] a, input logic w, input logic [2:0] sz,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; htrans <= RSC_HTRANS_NSEQ; hwrite <= w; hsize <= sz;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz = RSC_HSIZE_WORD);
    logic [31:0] x;
    bus(a, 1'b1, sz, d, x);
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, RSC_HSIZE_WORD, 32'h0, r);
    check_count++;
    if (r !== e || hresp !== 1'b0)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, r);
    end
  endtask
  task automatic chk_pins(input string nm, input logic [7:0] e);
    check_count++;
    if ({power_ctl, slew_ctl, gate} !== e)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, {power_ctl, slew_ctl, gate});
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk_pins("reset pins", 8'hFE);
    chk_reg("reset power", PM, 32'h0);
    chk_reg("reset slew", SL, 32'h5);
  endtask
  task automatic t_power;
    wr(PM, 32'h1); chk_pins("gate on", 8'hFF);
    wr(PM, 32'h2); chk_pins("regulators off", 8'h86);
    chk_reg("power rd 2", PM, 32'h2);
    wr(PM, 32'h4); chk_pins("bandgap off", 8'h06);
    wr(PM, 32'hFFFF_FFFF); chk_pins("all off", 8'h07);
    chk_reg("power reserved", PM, 32'h7);
    wr(PM, 32'h0); chk_pins("power on", 8'hFE);
  endtask
  task automatic t_wake(input logic alarm);
    int n;
    n = 0;
    wr(PM, 32'h7);
    @(posedge hclk);
    if (alarm) rtc_alarm <= 1'b1;
    else wake_pin <= 1'b1;
    while (power_ctl !== 5'h1F && n < 10)
    begin
      @(posedge hclk);
      n++;
    end
    #1;
    chk_pins("wake restore", 8'hFF);
    @(posedge hclk);
    rtc_alarm <= 1'b0;
    wake_pin <= 1'b0;
    chk_reg("wake bits", PM, 32'h1);
    wr(PM, 32'h0);
  endtask
  task automatic t_slew;
    wr(SL, 32'h0); chk_pins("slew slow", 8'hF8);
    wr(SL, 32'h4); chk_pins("clock fast", 8'hFC);
    chk_reg("slew rd 4", SL, 32'h4);
    wr(SL, 32'h1); chk_pins("memory fast", 8'hFA);
    wr(SL, 32'hFFFF_FFFF); chk_reg("slew reserved", SL, 32'h5);
  endtask
  task automatic t_refuse;
    wr(32'h0000_0100, 32'hFFFF_FFFF);
    chk_reg("unmapped", 32'h0000_0100, 32'h0);
    wr(SL, 32'h0, 3'h1); chk_reg("halfword write", SL, 32'h5);
    chk_pins("after refused", 8'hFE);
  endtask
  task automatic t_midrun_reset;
    wr(PM, 32'h7);
    wr(SL, 32'h0);
    chk_pins("before reset", 8'h01);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
  endtask
  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_power;
    t_wake(1'b0);
    t_wake(1'b1);
    t_slew;
    t_refuse;
    t_midrun_reset;
    conclude;
  end
  initial
  begin
    #20000;
    num_errors++;
    conclude;
  end
endmodule
